// >>> bench/port_clock_loop_polarity_ctl_test.sv
/*
 * port control bank bench: registers, clocks, loopback, alarms, inversion, reset.
 * assumes outputs lag inputs by one edge.
 */
`default_nettype none

module port_clock_loop_polarity_ctl_test
	import port_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [11:0] addr;
		logic [3:0]  strb;
		logic [31:0] wdata;
		logic [31:0] rexp;
		logic        err;
	} row_t;

	localparam row_t ROWS [9] = '{
		'{ADDR_CLOCK_TIMING, 4'hf, 32'hffff_ffff, 32'h0000_00ff, 1'b0},
		'{ADDR_LOOPBACK_ALARM, 4'hf, 32'hffff_ffff, 32'h0000_07ff, 1'b0},
		'{ADDR_TX_POLARITY, 4'hf, 32'hffff_ffff, 32'h0000_17ff, 1'b0},
		'{ADDR_TX_POLARITY, 4'h1, 32'h0000_0000, 32'h0000_1700, 1'b0},
		'{ADDR_LOOPBACK_ALARM, 4'h2, 32'h0000_0000, 32'h0000_00ff, 1'b0},
		'{12'h114, 4'hf, 32'hffff_ffff, 32'h0000_0000, 1'b1},
		'{12'h910, 4'hf, 32'h0000_0000, 32'h0000_0000, 1'b1},
		'{ADDR_CLOCK_TIMING, 4'h0, 32'h0000_0000, 32'h0000_00ff, 1'b0},
		'{ADDR_CLOCK_TIMING, 4'hf, 32'h0000_a5a5, 32'h0000_00a5, 1'b0}};
	localparam logic [3:0]  LB_EXP [8]  = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1, 4'h1, 4'h5, 4'h1};
	localparam logic [5:0]  AL_SEL [16] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h00,
		6'h00, 6'h00, 6'h00, 6'h00, 6'h0d, 6'h00, 6'h0d, 6'h30, 6'h3f};
	localparam logic [5:0]  ST [3]   = '{6'h2c, 6'h13, 6'h19};
	localparam logic [12:0] POL [4]  = '{13'h0000, 13'h17ff, 13'h0555, 13'h1aaa};
	localparam logic [12:0] CORE [3] = '{13'h0000, 13'h1fff, 13'h0a5a};

	logic        mclk, rst, psel, penable, pwrite, pready, pslverr, rd_err, en1, en2g, en2c;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic [5:0]  alarm_status, a;
	logic [4:0]  st_v;
	logic [12:0] core_v;
	wire logic [12:0] pin_v;
	wire logic [7:0]  clk_v;
	wire logic [3:0]  lb_v, gp_v;
	int          err_count, checked, i, j;

	port_clock_loop_polarity_ctl #(.ADDR_W(12)) dut (
		.mclk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.global_8k_ref(st_v[4]), .rx_framer_8k(st_v[3]), .tx_framer_8k(st_v[2]),
		.port_8k_ref(clk_v[7]), .one_sec_8k_ref(clk_v[6]), .rx_line_clock_pin(st_v[1]),
		.rate_adapter_clk(st_v[0]), .tx_clk_src(clk_v[5:4]), .tx_clk(clk_v[3]),
		.rx_framer_timing_sel(clk_v[2]), .tx_framer_timing_sel(clk_v[1]),
		.tx_line_timing_sel(clk_v[0]), .analog_loopback(lb_v[3]), .line_loopback(lb_v[2]),
		.payload_loopback(lb_v[1]), .diagnostic_loopback(lb_v[0]), .alarm_status,
		.pin_one_global_en(en1), .pin_two_global_en(en2g), .pin_two_ctrl_en(en2c),
		.general_pin_one(gp_v[3]), .general_pin_one_oe(gp_v[2]), .general_pin_two(gp_v[1]),
		.general_pin_two_oe(gp_v[0]), .tx_serial_core(core_v[10]),
		.tx_frame_start_out_core(core_v[12]), .tx_negative_line_core(core_v[4]),
		.tx_line_data_core(core_v[3]), .tx_line_clock_core(core_v[2]),
		.tx_clock_output_core(core_v[1]), .tx_overhead_frame_core(core_v[9]),
		.tx_overhead_enable_core(core_v[8]), .tx_overhead_clock_core(core_v[6]),
		.tx_serial_data_pin(pin_v[10]), .tx_frame_start_out_pin(pin_v[12]),
		.tx_negative_line_pin(pin_v[4]), .tx_line_data_pin(pin_v[3]), .tx_line_clock_pin(pin_v[2]),
		.tx_clock_output_pin(pin_v[1]), .tx_overhead_frame_pin(pin_v[9]),
		.tx_overhead_enable_pin(pin_v[8]), .tx_overhead_clock_pin(pin_v[6]),
		.tx_frame_start_in_pin(core_v[5]), .tx_overhead_data_pin(core_v[7]),
		.tx_clock_input_pin(core_v[0]), .tx_frame_start_in_core(pin_v[5]),
		.tx_overhead_data_core(pin_v[7]), .tx_clock_input_core(pin_v[0]));

	// ==========================================================
	// tasks
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		pstrb <= s;
		@(posedge mclk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++)
		begin
			@(posedge mclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 16)
		begin
			err_count++;
			give_verdict();
		end
		@(posedge mclk);
	endtask

	task automatic settle();
		repeat (2) @(posedge mclk);
	endtask

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	// expected clk_v with no loopback
	function automatic logic [7:0] clk_exp(input logic [7:0] c, input logic [5:0] s);
		logic       p;
		logic [1:0] src;
		p = c[7] & (c[6] ? s[3] : s[4]);
		src = c[4] ? 2'b11 : (c[3] ? 2'b00 : 2'b01);
		return {p, c[5] ? p : s[5], src, src[1] ? s[2] : (src[0] ? s[1] : s[0]), c[2:0]};
	endfunction

	// ==========================================================
	// stimulus
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, pstrb, st_v, core_v} = '0;
		{err_count, checked, alarm_status} = '0;
		{rst, en1, en2g, en2c} = 4'hf;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		for (i = 0; i < 3; i++)
		begin
			apb(1'b0, ROWS[i].addr, 32'h0, 4'h0);
			chk(rd, 32'h0);
		end
		chk(32'(clk_v[5:4]), 32'(TXSRC_RATE_ADAPT));
		done("reset values");
		foreach (ROWS[i])
		begin
			apb(1'b1, ROWS[i].addr, ROWS[i].wdata, ROWS[i].strb);
			chk(32'(rd_err), 32'(ROWS[i].err));
			apb(1'b0, ROWS[i].addr, 32'h0, 4'h0);
			chk(rd, ROWS[i].rexp);
			chk(32'(rd_err), 32'(ROWS[i].err));
		end
		done("register rows");
		apb(1'b1, ADDR_TX_POLARITY, 32'h0, 4'hf);
		for (i = 0; i < 256; i++)
		begin
			apb(1'b1, ADDR_CLOCK_TIMING, 32'(i), 4'hf);
			for (j = 0; j < 3; j++)
			begin
				st_v <= ST[j][5:1];
				core_v <= 13'(ST[j][0]);
				settle();
				chk(32'(clk_v), 32'(clk_exp(8'(i), ST[j])));
			end
		end
		done("clock sweep");
		apb(1'b1, ADDR_CLOCK_TIMING, 32'h08, 4'hf);
		for (i = 0; i < 8; i++)
		begin
			apb(1'b1, ADDR_LOOPBACK_ALARM, 32'(i) << 8, 4'hf);
			settle();
			chk(32'({lb_v, clk_v[5:4]}), 32'({LB_EXP[i], (i != 0) ? 2'b11 : 2'b00}));
		end
		done("loopback decode");
		for (i = 0; i < 16; i++)
		begin
			apb(1'b1, ADDR_LOOPBACK_ALARM, 32'(((15 - i) << 4) | i), 4'hf);
			for (j = 0; j < 2; j++)
			begin
				a = (j != 0) ? ~AL_SEL[i] : AL_SEL[i];
				alarm_status <= a;
				settle();
				chk(32'(gp_v), 32'({|(a & AL_SEL[i]), 1'b1, |(a & AL_SEL[15 - i]), 1'b1}));
			end
		end
		alarm_status <= 6'h3f;
		en1 <= 1'b0;
		en2c <= 1'b0;
		settle();
		chk(32'(gp_v), 32'h0);
		en1 <= 1'b1;
		en2c <= 1'b1;
		en2g <= 1'b0;
		settle();
		chk(32'(gp_v), 32'hc);
		en2g <= 1'b1;
		done("alarm pins");
		for (i = 0; i < 4; i++)
		begin
			apb(1'b1, ADDR_TX_POLARITY, 32'(POL[i]), 4'hf);
			for (j = 0; j < 3; j++)
			begin
				core_v <= CORE[j];
				settle();
				chk(32'(pin_v & 13'h17ff), 32'((CORE[j] ^ POL[i]) & 13'h17ff));
			end
		end
		done("pin inversion");
		apb(1'b1, ADDR_LOOPBACK_ALARM, 32'h0600, 4'hf);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		for (i = 0; i < 3; i++)
		begin
			apb(1'b0, ROWS[i].addr, 32'h0, 4'h0);
			chk(rd, 32'h0);
		end
		chk(32'({lb_v, clk_v[5:4]}), 32'({4'h0, TXSRC_RATE_ADAPT}));
		done("mid-run reset");
		give_verdict();
	end
endmodule

`default_nettype wire

// >>> bench/port_ctl_chk_sva.sv
/*
 * port control bank checker: bus errors, readback, pin gating, inversion, loopback.
 * assumes binding to the bank; sees only its ports.
 */
`default_nettype none

module port_ctl_chk
	import port_cfg_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	input wire logic              mclk,
	input wire logic              rst,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [31:0]       prdata,
	input wire logic              pslverr,
	input wire logic              pin_one_global_en,
	input wire logic              pin_two_global_en,
	input wire logic              pin_two_ctrl_en,
	input wire logic              general_pin_one,
	input wire logic              general_pin_one_oe,
	input wire logic              general_pin_two_oe,
	input wire logic              tx_serial_core,
	input wire logic              tx_serial_data_pin,
	input wire logic              tx_clock_input_pin,
	input wire logic              tx_clock_input_core,
	input wire logic [1:0]        tx_clk_src,
	input wire logic              analog_loopback,
	input wire logic              line_loopback,
	input wire logic              payload_loopback,
	input wire logic              diagnostic_loopback
);
	timeunit 1ns;
	timeprecision 1ps;

	wire logic wr_acc = psel & penable & pwrite;
	wire logic two_en = pin_two_global_en & pin_two_ctrl_en;
	wire logic any_lb = analog_loopback | line_loopback | payload_loopback | diagnostic_loopback;
	wire logic hit    = paddr == ADDR_W'(ADDR_CLOCK_TIMING) || paddr == ADDR_W'(ADDR_TX_POLARITY)
		|| paddr == ADDR_W'(ADDR_LOOPBACK_ALARM);

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// ==========================================================
	// register bus
	a_bad_addr_err: assert property (psel && penable |-> pslverr == !hit)
		else $error("pslverr wrong");
	a_upper_zero: assert property (psel && !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("upper half set");
	a_pol_reserved: assert property (psel && !pwrite && paddr == ADDR_W'(ADDR_TX_POLARITY)
		|-> (prdata[15:0] & ~MASK_TX_POLARITY) == 16'h0000)
		else $error("reserved bits set");

	// ==========================================================
	// alarm pins, inversion, loopback
	a_pin_one_gate: assert property (!pin_one_global_en [*2] |-> !general_pin_one && !general_pin_one_oe)
		else $error("pin one not gated");
	a_pin_two_gate: assert property (general_pin_two_oe |-> $past(two_en))
		else $error("pin two not gated");
	a_serial_follow: assert property ($changed(tx_serial_core) && !$past(wr_acc)
		|=> $changed(tx_serial_data_pin))
		else $error("serial pin stuck");
	a_clkin_follow: assert property ($changed(tx_clock_input_pin) && !$past(wr_acc)
		|=> $changed(tx_clock_input_core))
		else $error("clock input stuck");
	a_loop_exclusive: assert property (analog_loopback || payload_loopback
		|-> $onehot({analog_loopback, line_loopback, payload_loopback, diagnostic_loopback}))
		else $error("loopbacks overlap");
	a_src_no_loop: assert property (tx_clk_src == TXSRC_CLOCK_IN |-> !any_lb)
		else $error("clock input in loopback");
endmodule

bind port_clock_loop_polarity_ctl port_ctl_chk #(.ADDR_W(ADDR_W)) u_chk (
	.mclk, .rst, .paddr, .psel, .penable, .pwrite, .prdata, .pslverr, .pin_one_global_en,
	.pin_two_global_en, .pin_two_ctrl_en, .general_pin_one, .general_pin_one_oe,
	.general_pin_two_oe, .tx_serial_core, .tx_serial_data_pin, .tx_clock_input_pin,
	.tx_clock_input_core, .tx_clk_src, .analog_loopback, .line_loopback, .payload_loopback,
	.diagnostic_loopback);

`default_nettype wire

// >>> pkg/port_cfg_pkg.sv
/*
 * port configuration package: register indices, byte addresses, field positions,
 * reset values, field masks and enumerations for the port clock, loopback and
 * polarity control bank.
 * assumes a 32-bit APB slave with one aligned word per register.
 */
`default_nettype none

package port_cfg_pkg;

	// ==========================================================
	// register indices and byte addresses
	localparam logic [11:0] IDX_CLOCK_TIMING   = 12'h044;
	localparam logic [11:0] IDX_LOOPBACK_ALARM = 12'h046;
	localparam logic [11:0] IDX_TX_POLARITY    = 12'h04a;
	localparam logic [11:0] ADDR_CLOCK_TIMING   = 12'(IDX_CLOCK_TIMING << 2);
	localparam logic [11:0] ADDR_LOOPBACK_ALARM = 12'(IDX_LOOPBACK_ALARM << 2);
	localparam logic [11:0] ADDR_TX_POLARITY    = 12'(IDX_TX_POLARITY << 2);

	// ==========================================================
	// reset values and writable masks
	localparam logic [15:0] RST_CLOCK_TIMING   = 16'h0000;
	localparam logic [15:0] RST_LOOPBACK_ALARM = 16'h0000;
	localparam logic [15:0] RST_TX_POLARITY    = 16'h0000;
	localparam logic [15:0] MASK_CLOCK_TIMING   = 16'h00ff;
	localparam logic [15:0] MASK_LOOPBACK_ALARM = 16'h07ff;
	localparam logic [15:0] MASK_TX_POLARITY    = 16'h17ff;

	// ==========================================================
	// clock and timing control fields
	localparam int POS_REF_SRC_HI = 7;
	localparam int POS_REF_SRC_LO = 6;
	localparam int POS_ONE_SEC    = 5;
	localparam int POS_LOOP_TIME  = 4;
	localparam int POS_RATE_CTL   = 3;
	localparam int POS_RX_FRM_TS  = 2;
	localparam int POS_TX_FRM_TS  = 1;
	localparam int POS_TX_LINE_TS = 0;

	// ==========================================================
	// loopback and alarm select fields
	localparam int POS_LOOP_HI = 10;
	localparam int POS_LOOP_LO = 8;
	localparam int POS_PIN2_HI = 7;
	localparam int POS_PIN2_LO = 4;
	localparam int POS_PIN1_HI = 3;
	localparam int POS_PIN1_LO = 0;

	// ==========================================================
	// polarity fields
	localparam int POS_INV_FRAME_OUT = 12;
	localparam int POS_INV_SERIAL    = 10;
	localparam int POS_INV_OH_FRAME  = 9;
	localparam int POS_INV_OH_EN     = 8;
	localparam int POS_INV_OH_DATA   = 7;
	localparam int POS_INV_OH_CLK    = 6;
	localparam int POS_INV_FRAME_IN  = 5;
	localparam int POS_INV_NEG       = 4;
	localparam int POS_INV_DATA      = 3;
	localparam int POS_INV_LINE_CLK  = 2;
	localparam int POS_INV_CLK_OUT   = 1;
	localparam int POS_INV_CLK_IN    = 0;

	// ==========================================================
	// alarm vector bit order and enumerations
	localparam int ALARM_W = 6;
	localparam int ALM_LOS  = 0;
	localparam int ALM_OOF  = 1;
	localparam int ALM_LOF  = 2;
	localparam int ALM_AIS  = 3;
	localparam int ALM_RAI  = 4;
	localparam int ALM_IDLE = 5;

	typedef enum logic [1:0] {
		TXSRC_CLOCK_IN   = 2'b00,
		TXSRC_RATE_ADAPT = 2'b01,
		TXSRC_RX_CLOCK   = 2'b11
	} tx_clk_src_t;

endpackage

`default_nettype wire

// >>> src/alarm_pin_sel.sv
/*
 * one alarm pin: a four-bit code picks or combines alarms; enable gates the pin.
 * assumes alarm inputs synchronous to mclk.
 */
`default_nettype none

module alarm_pin_sel
	import port_cfg_pkg::*;
(
	input  wire logic               mclk,
	input  wire logic               rst,
	input  wire logic [3:0]         code,
	input  wire logic [ALARM_W-1:0] alarms,
	input  wire logic               out_enable,
	output logic                    pin_out,
	output logic                    pin_oe
);

	logic sel_d;

	// ==========================================================
	// code decode
	always_comb
	begin
		case (code)
			4'h0:    sel_d = alarms[ALM_LOS];   // [R11]
			4'h1:    sel_d = alarms[ALM_OOF];   // [R11]
			4'h2:    sel_d = alarms[ALM_LOF];   // [R11]
			4'h3:    sel_d = alarms[ALM_AIS];   // [R11]
			4'h4:    sel_d = alarms[ALM_RAI];   // [R11]
			4'h5:    sel_d = alarms[ALM_IDLE];  // [R11]
			4'hb,
			4'hd:    sel_d = alarms[ALM_LOS] | alarms[ALM_LOF] | alarms[ALM_AIS]; // [R11]
			4'he:    sel_d = alarms[ALM_RAI] | alarms[ALM_IDLE]; // [R11]
			4'hf:    sel_d = |alarms;           // [R11]
			default: sel_d = 1'b0;
		endcase
	end

	// ==========================================================
	// pin drive
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			pin_out <= 1'b0;
			pin_oe  <= 1'b0;
		end
		else
		begin
			pin_out <= sel_d & out_enable;
			pin_oe  <= out_enable;
		end
	end

endmodule

`default_nettype wire

// >>> src/port_clock_loop_polarity_ctl.sv
/*
 * port clock, loopback and polarity control bank: three 16-bit registers on
 * APB steering the 8 kHz reference muxes, transmit clock source, timing
 * selects, loopback decode, two alarm pins and transmit pin inversion.
 * assumes all pin and alarm inputs synchronous to mclk; zero-wait APB slave.
 */
//
// Contract
// R1: reference source 10 receive, 11 transmit clock; code selects tx_framer_8k for 11, not a clock
// R2: one-second reference global or port source
// R3: loop timing transmits on receive clock
// R4: rate-adapter clock used unless control bit set
// R5: receive framer timing output or input clocks
// R6: transmit framer timing output or input clocks
// R7: transmit line timing output or input clocks
// R8: loopback field decodes four loopback enables
// R9: upper alarm code drives pin two
// R10: lower alarm code drives pin one
// R11: alarm codes select or combine alarms
// R12: invert serial, frame-start out and in
// R13: invert overhead frame, enable, data, clock
// R14: invert negative, data and line clock
// R15: invert clock output and clock input
// R16: reserved bits read zero, writes ignored
`default_nettype none

module port_clock_loop_polarity_ctl
	import port_cfg_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	input  wire logic               mclk,
	input  wire logic               rst,
	// apb slave
	input  wire logic [ADDR_W-1:0]  paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	input  wire logic [3:0]         pstrb,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// 8 kHz references
	input  wire logic               global_8k_ref,
	input  wire logic               rx_framer_8k,
	input  wire logic               tx_framer_8k,
	output logic                    port_8k_ref,
	output logic                    one_sec_8k_ref,
	// transmit clock selection
	input  wire logic               rx_line_clock_pin,
	input  wire logic               rate_adapter_clk,
	output logic [1:0]              tx_clk_src,
	output logic                    tx_clk,
	// timing reference selects
	output logic                    rx_framer_timing_sel,
	output logic                    tx_framer_timing_sel,
	output logic                    tx_line_timing_sel,
	// loopback enables
	output logic                    analog_loopback,
	output logic                    line_loopback,
	output logic                    payload_loopback,
	output logic                    diagnostic_loopback,
	// alarm pins
	input  wire logic [ALARM_W-1:0] alarm_status,
	input  wire logic               pin_one_global_en,
	input  wire logic               pin_two_global_en,
	input  wire logic               pin_two_ctrl_en,
	output logic                    general_pin_one,
	output logic                    general_pin_one_oe,
	output logic                    general_pin_two,
	output logic                    general_pin_two_oe,
	// transmit pins driven out: core side in, pin side out
	input  wire logic               tx_serial_core,
	input  wire logic               tx_frame_start_out_core,
	input  wire logic               tx_negative_line_core,
	input  wire logic               tx_line_data_core,
	input  wire logic               tx_line_clock_core,
	input  wire logic               tx_clock_output_core,
	input  wire logic               tx_overhead_frame_core,
	input  wire logic               tx_overhead_enable_core,
	input  wire logic               tx_overhead_clock_core,
	output logic                    tx_serial_data_pin,
	output logic                    tx_frame_start_out_pin,
	output logic                    tx_negative_line_pin,
	output logic                    tx_line_data_pin,
	output logic                    tx_line_clock_pin,
	output logic                    tx_clock_output_pin,
	output logic                    tx_overhead_frame_pin,
	output logic                    tx_overhead_enable_pin,
	output logic                    tx_overhead_clock_pin,
	// transmit pins sampled in: pin side in, core side out
	input  wire logic               tx_frame_start_in_pin,
	input  wire logic               tx_overhead_data_pin,
	input  wire logic               tx_clock_input_pin,
	output logic                    tx_frame_start_in_core,
	output logic                    tx_overhead_data_core,
	output logic                    tx_clock_input_core
);

	// ==========================================================
	// elaboration check
	if (ADDR_W < 10 || ADDR_W > 32)
	begin : g_bad_addr_w
		$error("ADDR_W must lie between 10 and 32");
	end

	// ==========================================================
	// apb decode
	logic [15:0] clock_timing_q;
	logic [15:0] loopback_alarm_q;
	logic [15:0] polarity_q;
	logic [11:0] word_addr;
	logic        hit_clock;
	logic        hit_loop;
	logic        hit_pol;
	logic        mapped;
	logic        wr_en;
	logic [15:0] lane_mask;

	assign word_addr = {{(12 - 9){1'b0}}, paddr[8:0]};
	assign hit_clock = (word_addr == ADDR_CLOCK_TIMING) && (paddr[ADDR_W-1:9] == '0);
	assign hit_loop  = (word_addr == ADDR_LOOPBACK_ALARM) && (paddr[ADDR_W-1:9] == '0);
	assign hit_pol   = (word_addr == ADDR_TX_POLARITY) && (paddr[ADDR_W-1:9] == '0);
	assign mapped    = hit_clock | hit_loop | hit_pol;
	assign wr_en     = psel & penable & pwrite & mapped;
	assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	assign pready    = 1'b1;
	assign pslverr   = psel & penable & ~mapped;

	always_comb
	begin
		prdata = 32'h0000_0000;
		if (psel & ~pwrite)
		begin
			if (hit_clock)
				prdata = {16'h0000, clock_timing_q};
			else if (hit_loop)
				prdata = {16'h0000, loopback_alarm_q};
			else if (hit_pol)
				prdata = {16'h0000, polarity_q};
		end
	end

	// ==========================================================
	// register storage; unwritable bits stay zero
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			clock_timing_q <= RST_CLOCK_TIMING;
		else if (wr_en && hit_clock)
			clock_timing_q <= (clock_timing_q & ~lane_mask)
				| (pwdata[15:0] & lane_mask & MASK_CLOCK_TIMING); // [R16]
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			loopback_alarm_q <= RST_LOOPBACK_ALARM;
		else if (wr_en && hit_loop)
			loopback_alarm_q <= (loopback_alarm_q & ~lane_mask)
				| (pwdata[15:0] & lane_mask & MASK_LOOPBACK_ALARM); // [R16]
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			polarity_q <= RST_TX_POLARITY;
		else if (wr_en && hit_pol)
			polarity_q <= (polarity_q & ~lane_mask)
				| (pwdata[15:0] & lane_mask & MASK_TX_POLARITY); // [R16]
	end

	// ==========================================================
	// field views
	logic [1:0] port_ref_source_sel;
	logic       one_sec_ref_sel;
	logic       loop_timing_en;
	logic       rate_adapter_tx_clk_ctl;
	logic [2:0] loopback_mode_sel;
	logic [3:0] pin_one_alarm_sel;
	logic [3:0] pin_two_alarm_sel;

	assign port_ref_source_sel     = clock_timing_q[POS_REF_SRC_HI:POS_REF_SRC_LO];
	assign one_sec_ref_sel         = clock_timing_q[POS_ONE_SEC];
	assign loop_timing_en          = clock_timing_q[POS_LOOP_TIME];
	assign rate_adapter_tx_clk_ctl = clock_timing_q[POS_RATE_CTL];
	assign loopback_mode_sel       = loopback_alarm_q[POS_LOOP_HI:POS_LOOP_LO];
	assign pin_two_alarm_sel       = loopback_alarm_q[POS_PIN2_HI:POS_PIN2_LO];
	assign pin_one_alarm_sel       = loopback_alarm_q[POS_PIN1_HI:POS_PIN1_LO];

	// ==========================================================
	// 8 kHz reference selection
	logic port_ref_d;

	always_comb
	begin
		case (port_ref_source_sel)
			2'b10:   port_ref_d = rx_framer_8k;   // [R1]
			2'b11:   port_ref_d = tx_framer_8k;   // [R1]
			default: port_ref_d = 1'b0;           // undefined codes hold low
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			port_8k_ref    <= 1'b0;
			one_sec_8k_ref <= 1'b0;
		end
		else
		begin
			port_8k_ref    <= port_ref_d;
			one_sec_8k_ref <= one_sec_ref_sel ? port_ref_d : global_8k_ref; // [R2]
		end
	end

	// ==========================================================
	// loopback decode
	logic alb_d;
	logic llb_d;
	logic plb_d;
	logic dlb_d;

	always_comb
	begin
		alb_d = 1'b0;
		llb_d = 1'b0;
		plb_d = 1'b0;
		dlb_d = 1'b0;
		case (loopback_mode_sel)
			3'b000:  ;
			3'b001:  alb_d = 1'b1;                // [R8]
			3'b010:  llb_d = 1'b1;                // [R8]
			3'b011:  plb_d = 1'b1;                // [R8]
			3'b110:
			begin
				llb_d = 1'b1;                     // [R8]
				dlb_d = 1'b1;
			end
			default: dlb_d = 1'b1;                // [R8]
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			analog_loopback     <= 1'b0;
			line_loopback       <= 1'b0;
			payload_loopback    <= 1'b0;
			diagnostic_loopback <= 1'b0;
		end
		else
		begin
			analog_loopback     <= alb_d;
			line_loopback       <= llb_d;
			payload_loopback    <= plb_d;
			diagnostic_loopback <= dlb_d;
		end
	end

	// ==========================================================
	// transmit clock source
	tx_clk_src_t src_d;
	logic        clk_in_core_d;

	assign clk_in_core_d = tx_clock_input_pin ^ polarity_q[POS_INV_CLK_IN]; // [R15]

	always_comb
	begin
		if (loop_timing_en)
			src_d = TXSRC_RX_CLOCK;               // [R3]
		else if (!rate_adapter_tx_clk_ctl)
			src_d = TXSRC_RATE_ADAPT;             // [R4]
		else if (alb_d | llb_d | plb_d | dlb_d)
			src_d = TXSRC_RX_CLOCK;
		else
			src_d = TXSRC_CLOCK_IN;               // [R4]
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			tx_clk_src <= TXSRC_RATE_ADAPT;
			tx_clk     <= 1'b0;
		end
		else
		begin
			tx_clk_src <= src_d;
			case (src_d)
				TXSRC_RX_CLOCK:   tx_clk <= rx_line_clock_pin;   // [R3]
				TXSRC_RATE_ADAPT: tx_clk <= rate_adapter_clk;    // [R4]
				TXSRC_CLOCK_IN:   tx_clk <= clk_in_core_d;
				default:          tx_clk <= 1'b0;
			endcase
		end
	end

	// ==========================================================
	// timing reference selects
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			rx_framer_timing_sel <= 1'b0;
			tx_framer_timing_sel <= 1'b0;
			tx_line_timing_sel   <= 1'b0;
		end
		else
		begin
			rx_framer_timing_sel <= clock_timing_q[POS_RX_FRM_TS];  // [R5]
			tx_framer_timing_sel <= clock_timing_q[POS_TX_FRM_TS];  // [R6]
			tx_line_timing_sel   <= clock_timing_q[POS_TX_LINE_TS]; // [R7]
		end
	end

	// ==========================================================
	// alarm pins
	logic [1:0]  pin_en;
	logic [7:0]  pin_codes;
	logic [1:0]  pin_val;
	logic [1:0]  pin_oe;

	assign pin_en    = {pin_two_global_en & pin_two_ctrl_en, pin_one_global_en}; // [R9] [R10]
	assign pin_codes = {pin_two_alarm_sel, pin_one_alarm_sel};

	for (genvar i = 0; i < 2; i++)
	begin : g_alarm_pin
		alarm_pin_sel u_sel (
			.mclk       (mclk),
			.rst        (rst),
			.code       (pin_codes[4*i +: 4]),
			.alarms     (alarm_status),
			.out_enable (pin_en[i]),
			.pin_out    (pin_val[i]),
			.pin_oe     (pin_oe[i])
		);
	end

	assign general_pin_one    = pin_val[0];
	assign general_pin_one_oe = pin_oe[0];
	assign general_pin_two    = pin_val[1];
	assign general_pin_two_oe = pin_oe[1];

	// ==========================================================
	// pin polarity
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			tx_serial_data_pin     <= 1'b0;
			tx_frame_start_out_pin <= 1'b0;
			tx_frame_start_in_core <= 1'b0;
			tx_overhead_frame_pin  <= 1'b0;
			tx_overhead_enable_pin <= 1'b0;
			tx_overhead_data_core  <= 1'b0;
			tx_overhead_clock_pin  <= 1'b0;
			tx_negative_line_pin   <= 1'b0;
			tx_line_data_pin       <= 1'b0;
			tx_line_clock_pin      <= 1'b0;
			tx_clock_output_pin    <= 1'b0;
			tx_clock_input_core    <= 1'b0;
		end
		else
		begin
			tx_serial_data_pin     <= tx_serial_core ^ polarity_q[POS_INV_SERIAL];            // [R12]
			tx_frame_start_out_pin <= tx_frame_start_out_core ^ polarity_q[POS_INV_FRAME_OUT]; // [R12]
			tx_frame_start_in_core <= tx_frame_start_in_pin ^ polarity_q[POS_INV_FRAME_IN];    // [R12]
			tx_overhead_frame_pin  <= tx_overhead_frame_core ^ polarity_q[POS_INV_OH_FRAME];  // [R13]
			tx_overhead_enable_pin <= tx_overhead_enable_core ^ polarity_q[POS_INV_OH_EN];    // [R13]
			tx_overhead_data_core  <= tx_overhead_data_pin ^ polarity_q[POS_INV_OH_DATA];     // [R13]
			tx_overhead_clock_pin  <= tx_overhead_clock_core ^ polarity_q[POS_INV_OH_CLK];    // [R13]
			tx_negative_line_pin   <= tx_negative_line_core ^ polarity_q[POS_INV_NEG];        // [R14]
			tx_line_data_pin       <= tx_line_data_core ^ polarity_q[POS_INV_DATA];           // [R14]
			tx_line_clock_pin      <= tx_line_clock_core ^ polarity_q[POS_INV_LINE_CLK];      // [R14]
			tx_clock_output_pin    <= tx_clock_output_core ^ polarity_q[POS_INV_CLK_OUT];     // [R15]
			tx_clock_input_core    <= clk_in_core_d;                                          // [R15]
		end
	end

endmodule

`default_nettype wire
